// [src/accel_readout_pkg.sv]
// Constants for the accelerometer sample and status readout.
// Assumes one system clock and a synchronous active-high reset.
package accel_readout_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_SAMPLE_STATUS = 8'h00;
    localparam logic [7:0] ADDR_X_MSB         = 8'h01;
    localparam logic [7:0] ADDR_Z_MSB         = 8'h05;
    localparam logic [7:0] ADDR_Z_LSB         = 8'h06;
    localparam logic [7:0] ADDR_INT_CONFIG    = 8'h2E;
    localparam logic [7:0] ADDR_X_OFFSET      = 8'h2F;
    localparam logic [7:0] ADDR_Y_OFFSET      = 8'h30;
    localparam logic [7:0] ADDR_Z_OFFSET      = 8'h31;

    // ----------------------------------------------------------------
    // Widths, field positions and reset values
    // ----------------------------------------------------------------
    localparam int         SAMPLE_W       = 12;
    localparam int         AXES           = 3;
    localparam int         LOW_NIBBLE_W   = 4;
    localparam int         BIT_ANY_OW     = 7;
    localparam int         BIT_AXIS_OW_LO = 4;
    localparam int         BIT_ANY_READY  = 3;
    localparam int         BIT_AXIS_RD_LO = 0;
    localparam logic [7:0] INT_CFG_MASK   = 8'hFD;
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    localparam logic [1:0] BUF_MODE_OFF   = 2'h0;

    typedef logic [7:0] byte_t;

endpackage : accel_readout_pkg

// [src/axis_if.sv]
// Carrier between the readout and one per-axis sample holder.
// Assumes both ends share the system clock.
interface axis_if;
    logic        sample_valid;
    logic [11:0] sample;
    logic        msb_rd;
    logic [7:0]  msb_byte;
    logic [7:0]  lsb_byte;
    logic        ready;
    logic        overwrite;
    logic        ow_event;

    modport chan (
        input  sample_valid, sample, msb_rd,
        output msb_byte, lsb_byte, ready, overwrite, ow_event
    );
    modport ctrl (
        output sample_valid, sample, msb_rd,
        input  msb_byte, lsb_byte, ready, overwrite, ow_event
    );
endinterface : axis_if

// [src/axis_sample_holder.sv]
// One axis: sample register, ready and overwrite flags, low-byte hold.
// Assumes samples and reads come from logic on the system clock.
module axis_sample_holder (
    input  wire logic i_clk_sys,
    input  wire logic i_srst,
    axis_if.chan      io_axis
);
    import accel_readout_pkg::*;

    logic [SAMPLE_W-1:0] data_q,  data_d;
    logic                ready_q, ready_d;
    logic                ow_q,    ow_d;
    byte_t               lsb_q,   lsb_d;

    // ----------------------------------------------------------------
    // Flag and data update
    // ----------------------------------------------------------------
    always_comb begin
        data_d  = data_q;
        ready_d = ready_q;
        ow_d    = ow_q;
        lsb_d   = lsb_q;
        if (io_axis.msb_rd) begin
            ready_d = 1'b0;
            ow_d    = 1'b0;
            lsb_d   = {data_q[LOW_NIBBLE_W-1:0], 4'h0};
        end
        if (io_axis.sample_valid) begin
            data_d  = io_axis.sample;
            ready_d = 1'b1;
            if (ready_q) begin
                ow_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            data_q  <= '0;
            ready_q <= 1'b0;
            ow_q    <= 1'b0;
            lsb_q   <= RESET_BYTE;
        end else begin
            data_q  <= data_d;
            ready_q <= ready_d;
            ow_q    <= ow_d;
            lsb_q   <= lsb_d;
        end
    end

    // High byte holds bits 11..4; low byte is left aligned
    assign io_axis.msb_byte  = data_q[SAMPLE_W-1:LOW_NIBBLE_W];
    assign io_axis.lsb_byte  = lsb_q;
    assign io_axis.ready     = ready_q;
    assign io_axis.overwrite = ow_q;
    assign io_axis.ow_event  = io_axis.sample_valid & ready_q;

endmodule : axis_sample_holder

// [src/accel_sample_readout.sv]
// Register readout of a three-axis accelerometer: status, samples,
// interrupt configuration and zero-g offsets.
// Assumes the serial port shim delivers byte reads and writes as
// one-cycle strobes on the system clock.
//
// Behaviour
// - Buffer off: address 0x00 shows live ready and overwrite flags.
// - Buffer mode nonzero: address 0x00 shows buffer status instead.
// - Fast-read set: auto-increment skips every low data byte.
// - Fast-read clear: burst returns X, Y, Z high then low bytes.
// - Samples are 12-bit two's complement, high byte plus left-aligned low.
// - Status bits 7..4 overwrite flags, bits 3..0 ready flags.
// - Combined overwrite sets when new data overwrites unread data.
// - Combined overwrite clears after all three high bytes are read.
// - Axis overwrite sets when a new sample replaces an unread one.
// - Reading an axis high byte clears its overwrite flag.
// - Interrupt config holds one routing bit per source, bit 1 unused.
// - Combined ready sets on any new sample, clears once all three high bytes are read.
// - Axis ready sets on new sample, clears on its high-byte read.
// - Low byte readable only right after its high byte, same sample.
// - Buffer on: 0x02..0x06 read zero, 0x01 reads buffer data.
module accel_sample_readout (
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_srst,
    input  wire logic                        i_addr_load,
    input  wire accel_readout_pkg::byte_t    i_addr,
    input  wire logic                        i_rd,
    input  wire logic                        i_wr,
    input  wire accel_readout_pkg::byte_t    i_wdata,
    input  wire logic [2:0]                  i_sample_valid,
    input  wire logic [11:0]                 i_sample_x,
    input  wire logic [11:0]                 i_sample_y,
    input  wire logic [11:0]                 i_sample_z,
    input  wire logic [1:0]                  i_buffer_mode,
    input  wire logic                        i_fast_read,
    input  wire accel_readout_pkg::byte_t    i_buffer_status,
    input  wire accel_readout_pkg::byte_t    i_buffer_data,
    output logic                             o_rvalid,
    output accel_readout_pkg::byte_t         o_rdata,
    output logic                             o_buffer_pop,
    output accel_readout_pkg::byte_t         o_interrupt_config,
    output accel_readout_pkg::byte_t         o_x_zero_g_offset,
    output accel_readout_pkg::byte_t         o_y_zero_g_offset,
    output accel_readout_pkg::byte_t         o_z_zero_g_offset
);
    import accel_readout_pkg::*;

    // ----------------------------------------------------------------
    // Next pointer after an access
    // ----------------------------------------------------------------
    function automatic byte_t next_addr(input byte_t a, input logic fast);
        byte_t n;
        n = a + 8'h01;
        if (a >= ADDR_X_MSB && a <= ADDR_Z_LSB) begin
            if (fast) begin
                n = (a == ADDR_Z_MSB) ? ADDR_SAMPLE_STATUS
                                      : a + 8'h02;
            end else if (a == ADDR_Z_LSB) begin
                n = ADDR_SAMPLE_STATUS;
            end
        end
        return n;
    endfunction : next_addr

    // ----------------------------------------------------------------
    // Per-axis holders
    // ----------------------------------------------------------------
    axis_if ax [AXES] ();

    logic [AXES-1:0] ready_v, ow_v, ow_ev_v, msb_rd_v;
    byte_t           msb_v [AXES];
    byte_t           lsb_v [AXES];
    logic [11:0]     smp_v [AXES];

    assign smp_v[0] = i_sample_x;
    assign smp_v[1] = i_sample_y;
    assign smp_v[2] = i_sample_z;

    for (genvar g = 0; g < AXES; g++) begin : g_axis
        assign ax[g].sample_valid = i_sample_valid[g];
        assign ax[g].sample       = smp_v[g];
        assign ax[g].msb_rd       = msb_rd_v[g];
        assign msb_v[g]           = ax[g].msb_byte;
        assign lsb_v[g]           = ax[g].lsb_byte;
        assign ready_v[g]         = ax[g].ready;
        assign ow_v[g]            = ax[g].overwrite;
        assign ow_ev_v[g]         = ax[g].ow_event;
        axis_sample_holder u_holder (
            .i_clk_sys (i_clk_sys),
            .i_srst    (i_srst),
            .io_axis   (ax[g])
        );
    end

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    byte_t           ptr_q,     ptr_d;
    byte_t           rdata_q,   rdata_d;
    logic            rvalid_q,  rvalid_d;
    logic            pop_q,     pop_d;
    byte_t           intcfg_q,  intcfg_d;
    byte_t           off_q [AXES];
    byte_t           off_d [AXES];
    logic            any_ow_q,  any_ow_d;
    logic            any_rdy_q, any_rdy_d;
    logic [AXES-1:0] seen_q,    seen_d;
    logic [AXES-1:0] lsb_ok_q,  lsb_ok_d;

    logic            buf_on;
    logic [AXES-1:0] seen_all;
    int unsigned     ax_i;

    assign buf_on = (i_buffer_mode != BUF_MODE_OFF);

    always_comb begin
        ptr_d     = ptr_q;
        rdata_d   = rdata_q;
        rvalid_d  = 1'b0;
        pop_d     = 1'b0;
        intcfg_d  = intcfg_q;
        off_d     = off_q;
        any_ow_d  = any_ow_q;
        any_rdy_d = any_rdy_q;
        seen_d    = seen_q;
        lsb_ok_d  = lsb_ok_q;
        msb_rd_v  = '0;
        seen_all  = '0;
        ax_i      = 0;

        if (i_addr_load) begin
            ptr_d    = i_addr;
            lsb_ok_d = '0;
        end else if (i_wr) begin
            case (ptr_q)
                ADDR_INT_CONFIG: intcfg_d = i_wdata & INT_CFG_MASK;
                ADDR_X_OFFSET:   off_d[0] = i_wdata;
                ADDR_Y_OFFSET:   off_d[1] = i_wdata;
                ADDR_Z_OFFSET:   off_d[2] = i_wdata;
                default:         ;
            endcase
            ptr_d    = next_addr(ptr_q, i_fast_read);
            lsb_ok_d = '0;
        end else if (i_rd) begin
            rvalid_d = 1'b1;
            lsb_ok_d = '0;
            rdata_d  = RESET_BYTE;
            ax_i     = (32'(ptr_q) - 32'(ADDR_X_MSB)) >> 1;
            case (ptr_q)
                ADDR_SAMPLE_STATUS: begin
                    if (buf_on) begin
                        rdata_d = i_buffer_status;
                    end else begin
                        rdata_d = {any_ow_q, ow_v[2], ow_v[1], ow_v[0],
                                   any_rdy_q, ready_v[2], ready_v[1],
                                   ready_v[0]};
                    end
                end
                8'h01, 8'h03, ADDR_Z_MSB: begin
                    if (buf_on) begin
                        if (ptr_q == ADDR_X_MSB) begin
                            rdata_d = i_buffer_data;
                            pop_d   = 1'b1;
                        end
                    end else begin
                        rdata_d         = msb_v[ax_i];
                        msb_rd_v[ax_i]  = 1'b1;
                        seen_d[ax_i]    = 1'b1;
                        lsb_ok_d[ax_i]  = 1'b1;
                    end
                end
                8'h02, 8'h04, ADDR_Z_LSB: begin
                    if (!buf_on && lsb_ok_q[ax_i]) begin
                        rdata_d = lsb_v[ax_i];
                    end
                end
                ADDR_INT_CONFIG: rdata_d = intcfg_q;
                ADDR_X_OFFSET:   rdata_d = off_q[0];
                ADDR_Y_OFFSET:   rdata_d = off_q[1];
                ADDR_Z_OFFSET:   rdata_d = off_q[2];
                default:         rdata_d = RESET_BYTE;
            endcase
            ptr_d = next_addr(ptr_q, i_fast_read);
        end

        // Combined flags clear once every high byte was read
        seen_all = {AXES{1'b1}};
        if (seen_d == seen_all) begin
            any_ow_d  = 1'b0;
            any_rdy_d = 1'b0;
            seen_d    = '0;
        end
        // A new sample wins over a clear in the same cycle
        if (|ow_ev_v) begin
            any_ow_d = 1'b1;
        end
        if (|i_sample_valid) begin
            any_rdy_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ptr_q     <= ADDR_SAMPLE_STATUS;
            rdata_q   <= RESET_BYTE;
            rvalid_q  <= 1'b0;
            pop_q     <= 1'b0;
            intcfg_q  <= RESET_BYTE;
            off_q     <= '{default: RESET_BYTE};
            any_ow_q  <= 1'b0;
            any_rdy_q <= 1'b0;
            seen_q    <= '0;
            lsb_ok_q  <= '0;
        end else begin
            ptr_q     <= ptr_d;
            rdata_q   <= rdata_d;
            rvalid_q  <= rvalid_d;
            pop_q     <= pop_d;
            intcfg_q  <= intcfg_d;
            off_q     <= off_d;
            any_ow_q  <= any_ow_d;
            any_rdy_q <= any_rdy_d;
            seen_q    <= seen_d;
            lsb_ok_q  <= lsb_ok_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rvalid           = rvalid_q;
    assign o_rdata            = rdata_q;
    assign o_buffer_pop       = pop_q;
    assign o_interrupt_config = intcfg_q;
    assign o_x_zero_g_offset  = off_q[0];
    assign o_y_zero_g_offset  = off_q[1];
    assign o_z_zero_g_offset  = off_q[2];

endmodule : accel_sample_readout

// [dv/readout_props.sv]
// Checker for the readout register port.
// Assumes it is bound to accel_sample_readout.
module readout_props
    import accel_readout_pkg::*;
(
    input wire logic                     i_clk_sys,
    input wire logic                     i_srst,
    input wire logic                     i_addr_load,
    input wire accel_readout_pkg::byte_t i_addr,
    input wire logic                     i_rd,
    input wire logic                     i_wr,
    input wire accel_readout_pkg::byte_t i_wdata,
    input wire logic [1:0]               i_buffer_mode,
    input wire accel_readout_pkg::byte_t i_buffer_status,
    input wire accel_readout_pkg::byte_t i_buffer_data,
    input wire logic                     o_rvalid,
    input wire accel_readout_pkg::byte_t o_rdata,
    input wire logic                     o_buffer_pop,
    input wire accel_readout_pkg::byte_t o_interrupt_config,
    input wire accel_readout_pkg::byte_t o_x_zero_g_offset
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    wire take_rd = i_rd && !i_wr && !i_addr_load;
    wire take_wr = i_wr && !i_addr_load;
    sequence s_point(logic [7:0] a);
        i_addr_load && i_addr == a;
    endsequence
    sequence s_idle;
        !i_addr_load && !i_rd && !i_wr;
    endsequence
    sequence s_buf_rd;
        take_rd && i_buffer_mode != BUF_MODE_OFF;
    endsequence
    rd_answer_a: assert property (take_rd |=> o_rvalid)
        else $error("read not answered");
    rd_quiet_a: assert property (!take_rd |=> !o_rvalid)
        else $error("answer without read");
    rdata_hold_a: assert property (
        !o_rvalid && !$past(i_srst) |-> $stable(o_rdata))
        else $error("read data moved without read");
    cfg_bit1_a: assert property (o_interrupt_config[1] == 1'b0)
        else $error("unused config bit set");
    pop_off_a: assert property (
        i_buffer_mode == BUF_MODE_OFF |=> !o_buffer_pop)
        else $error("buffer pop while buffer off");
    offs_hold_a: assert property (!i_wr |=> $stable(o_x_zero_g_offset))
        else $error("offset changed without write");
    offx_wr_a: assert property (
        s_point(ADDR_X_OFFSET) ##1 s_idle ##1 take_wr
        |=> o_x_zero_g_offset == $past(i_wdata))
        else $error("offset write lost");
    cfg_wr_a: assert property (
        s_point(ADDR_INT_CONFIG) ##1 s_idle ##1 take_wr
        |=> o_interrupt_config == ($past(i_wdata) & INT_CFG_MASK))
        else $error("config write lost");
    buf_data_a: assert property (
        s_point(ADDR_X_MSB) ##1 s_idle ##1 s_buf_rd
        |=> o_rdata == $past(i_buffer_data) && o_buffer_pop)
        else $error("buffer data not returned");
    buf_stat_a: assert property (
        s_point(ADDR_SAMPLE_STATUS) ##1 s_idle ##1 s_buf_rd
        |=> o_rdata == $past(i_buffer_status) && !o_buffer_pop)
        else $error("buffer status not returned");
endmodule : readout_props

bind accel_sample_readout readout_props i_readout_props (.*);

// [dv/host_model.sv]
// Host on the register port: pointer loads, byte reads and writes.
// Assumes one-cycle strobes taken on the rising clock edge.
module host_model (
    input  wire logic                     i_clk,
    input  wire logic                     i_rvalid,
    input  wire accel_readout_pkg::byte_t i_rdata,
    output logic                          o_addr_load,
    output accel_readout_pkg::byte_t      o_addr,
    output logic                          o_rd,
    output logic                          o_wr,
    output accel_readout_pkg::byte_t      o_wdata
);
    import accel_readout_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_addr_load = 1'b0;
        o_addr = 8'h00;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 8'h00;
    end
    // Released address and data show the inverse of the last value
    task automatic load(input byte_t a);
        @(posedge i_clk);
        o_addr_load <= 1'b1;
        o_addr      <= a;
        @(posedge i_clk);
        o_addr_load <= 1'b0;
        o_addr      <= ~a;
    endtask : load
    task automatic wr(input byte_t v);
        @(posedge i_clk);
        o_wr    <= 1'b1;
        o_wdata <= v;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~v;
    endtask : wr
    task automatic rd(output byte_t v);
        @(posedge i_clk);
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        @(negedge i_clk);
        v = i_rvalid ? i_rdata : 8'hXX;
    endtask : rd
endmodule : host_model

// [dv/tb_top.sv]
// Self-checking bench for the sample and status readout.
// Assumes the host model on the register port and the bound checker.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import accel_readout_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        addr_load, rd, wr, rvalid, pop;
    logic        fast = 1'b0;
    byte_t       addr, wdata, rdata, cfg, offx, offy, offz, d, w;
    byte_t       bstat = 8'h00;
    byte_t       bdata = 8'h00;
    logic [2:0]  valid = 3'h0;
    logic [1:0]  mode = 2'h0;
    logic [11:0] smp [3] = '{default: 12'h000};
    logic [11:0] v;
    byte_t       exp_reg [4];
    int          failures = 0;
    int          checked = 0;
    always #50 clk = ~clk;
    accel_sample_readout i_accel_sample_readout (
        .i_clk_sys(clk), .i_srst(srst), .i_addr_load(addr_load),
        .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata),
        .i_sample_valid(valid), .i_sample_x(smp[0]), .i_sample_y(smp[1]),
        .i_sample_z(smp[2]), .i_buffer_mode(mode), .i_fast_read(fast),
        .i_buffer_status(bstat), .i_buffer_data(bdata),
        .o_rvalid(rvalid), .o_rdata(rdata), .o_buffer_pop(pop),
        .o_interrupt_config(cfg), .o_x_zero_g_offset(offx),
        .o_y_zero_g_offset(offy), .o_z_zero_g_offset(offz));
    host_model i_host_model (
        .i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata),
        .o_addr_load(addr_load), .o_addr(addr), .o_rd(rd), .o_wr(wr),
        .o_wdata(wdata));
    function automatic byte_t hi(logic [11:0] s);
        return s[11:4];
    endfunction : hi
    function automatic byte_t lo(logic [11:0] s);
        return {s[3:0], 4'h0};
    endfunction : lo
    task chk(byte_t got, byte_t exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task rd_at(byte_t a, byte_t exp);
        i_host_model.load(a);
        i_host_model.rd(d);
        chk(d, exp);
    endtask : rd_at
    task wr_at(byte_t a, byte_t x);
        i_host_model.load(a);
        i_host_model.wr(x);
    endtask : wr_at
    task push(int ax, logic [11:0] s);
        @(posedge clk);
        valid[ax] <= 1'b1;
        smp[ax]   <= s;
        @(posedge clk);
        valid[ax] <= 1'b0;
    endtask : push
    task end_of_test;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        end_of_test();
    end
    initial begin
        w = 8'($urandom(32'hd83b9309));
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd_at(ADDR_SAMPLE_STATUS, 8'h00);
        rd_at(ADDR_X_OFFSET, RESET_BYTE);
        $display("test reset done");
        for (int a = 8'h2E; a <= 8'h31; a++) begin
            w = 8'($urandom);
            exp_reg[a - 8'h2E] = a == 8'h2E ? w & INT_CFG_MASK : w;
            wr_at(byte_t'(a), w);
            rd_at(byte_t'(a), exp_reg[a - 8'h2E]);
        end
        chk(cfg, exp_reg[0]);
        chk(offx, exp_reg[1]);
        chk(offy, exp_reg[2]);
        chk(offz, exp_reg[3]);
        wr_at(ADDR_INT_CONFIG, 8'hFF);
        rd_at(ADDR_INT_CONFIG, 8'hFD);
        wr_at(8'h40, 8'hFF);
        rd_at(8'h40, 8'h00);
        wr_at(ADDR_SAMPLE_STATUS, 8'hFF);
        rd_at(ADDR_SAMPLE_STATUS, 8'h00);
        $display("test registers done");
        push(0, 12'h800);
        push(1, 12'h7FF);
        push(2, 12'($urandom));
        rd_at(ADDR_SAMPLE_STATUS, 8'h0F);
        i_host_model.load(ADDR_X_MSB);
        for (int k = 0; k < 6; k++) begin
            i_host_model.rd(d);
            chk(d, k[0] ? lo(smp[k / 2]) : hi(smp[k / 2]));
        end
        rd_at(ADDR_SAMPLE_STATUS, 8'h00);
        $display("test burst done");
        push(0, 12'($urandom));
        push(0, 12'($urandom));
        rd_at(ADDR_SAMPLE_STATUS, 8'h99);
        rd_at(ADDR_X_MSB, hi(smp[0]));
        rd_at(ADDR_SAMPLE_STATUS, 8'h88);
        rd_at(8'h03, hi(smp[1]));
        rd_at(ADDR_Z_MSB, hi(smp[2]));
        rd_at(ADDR_SAMPLE_STATUS, 8'h00);
        $display("test overwrite done");
        i_host_model.load(ADDR_X_MSB);
        i_host_model.rd(d);
        v = smp[0];
        push(0, ~v);
        i_host_model.rd(d);
        chk(d, lo(v));
        rd_at(8'h02, 8'h00);
        rd_at(ADDR_X_MSB, hi(smp[0]));
        $display("test low byte done");
        @(posedge clk);
        fast <= 1'b1;
        for (int k = 0; k < 3; k++) push(k, 12'($urandom));
        i_host_model.load(ADDR_X_MSB);
        for (int k = 0; k < 3; k++) begin
            i_host_model.rd(d);
            chk(d, hi(smp[k]));
        end
        i_host_model.rd(d);
        chk(d, 8'h00);
        @(posedge clk);
        fast <= 1'b0;
        $display("test fast read done");
        for (int m = 1; m < 4; m++) begin
            @(posedge clk);
            mode  <= 2'(m);
            bstat <= 8'($urandom);
            bdata <= 8'($urandom);
            @(negedge clk);
            rd_at(ADDR_SAMPLE_STATUS, bstat);
            rd_at(ADDR_X_MSB, bdata);
            for (int a = 2; a <= 6; a++) rd_at(byte_t'(a), 8'h00);
        end
        $display("test buffer done");
        end_of_test();
    end
endmodule : tb_top
